// ==== dv/warmup_counter_props.sv ====
// Port checks for the warm-up counter
`timescale 1ns/1ps
module warmup_counter_props (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic core_reset_n_o,
    input wire logic resume_o,
    input wire logic warmup_done_interrupt_o,
    input wire logic high_osc_en_o,
    input wire logic low_osc_en_o,
    input wire logic stop_mode_o
);
    // ========================================
    // Bus, warm-up and stop checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    a_upper_bits_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_core_rst_hold: assert property (core_reset_n_o |=> core_reset_n_o)
        else $error("core reset asserted again");
    a_int_after_boot: assert property (warmup_done_interrupt_o |-> core_reset_n_o)
        else $error("interrupt while core held in reset");
    a_int_one_pulse: assert property (warmup_done_interrupt_o |=> !warmup_done_interrupt_o)
        else $error("interrupt longer than one cycle");
    a_resume_pulse: assert property (resume_o |=> !resume_o && !stop_mode_o)
        else $error("resume pulse malformed");
    a_stop_osc_off: assert property (stop_mode_o |-> !high_osc_en_o && !low_osc_en_o
        && !resume_o && !warmup_done_interrupt_o)
        else $error("oscillator enabled in stop");
endmodule : warmup_counter_props

bind warmup_counter warmup_counter_props u_warmup_counter_props (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .core_reset_n_o(core_reset_n_o), .resume_o(resume_o),
    .warmup_done_interrupt_o(warmup_done_interrupt_o), .high_osc_en_o(high_osc_en_o),
    .low_osc_en_o(low_osc_en_o), .stop_mode_o(stop_mode_o));

// ==== dv/warmup_counter_tb.sv ====
// Self-checking bench for the warm-up counter
`timescale 1ns/1ps
module warmup_counter_tb;
    logic clk, rst_n, cyc, stb, we, ack, hclk, lclk, stop_en, stop_rel;
    logic core_rst_n, resume, irq, hen, len, stop_mode;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, rd;
    int bad_count = 0;
    int compares = 0;
    int n;

    warmup_counter u_warmup_counter (.core_clk_i(clk), .reset_n_i(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .high_freq_clock_i(hclk), .low_freq_clock_i(lclk),
        .stop_enter_i(stop_en), .stop_release_i(stop_rel), .core_reset_n_o(core_rst_n),
        .resume_o(resume), .warmup_done_interrupt_o(irq), .high_osc_en_o(hen),
        .low_osc_en_o(len), .stop_mode_o(stop_mode));
    warmup_osc_model u_warmup_osc_model (.high_en_i(hen), .low_en_i(len),
        .high_clk_o(hclk), .low_clk_o(lclk));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ========================================
    // Shared tasks
    task automatic print_verdict();
        if (bad_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Classic cycle: hold request until ack is sampled, then release
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        chk("bus ack", 32'h0000_0001, {31'h0, ack});
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    // Cycles until irq (0), resume (1) or core release (2), or lim
    task automatic wait_evt(input int which, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!((which == 0) ? irq === 1'b1 : (which == 1) ? resume === 1'b1
                   : core_rst_n === 1'b1) && n < lim);
    endtask : wait_evt

    task automatic near(input string name, input int exp);
        logic in_band;
        in_band = n > exp - exp / 8 - 12 && n < exp + exp / 8 + 12;
        chk(name, 32'(exp), in_band ? 32'(exp) : 32'(n));
    endtask : near

    // ========================================
    // Scenarios
    task automatic t_reset();
        wb(1'b0, warmup_pkg::OFF_CONTROL, 0);
        chk("control reset", 32'h0000_0006, rd);
        // A write with lane zero off is refused
        sel <= 4'hE;
        wb(1'b1, warmup_pkg::OFF_LIMIT, 32'h0000_0055);
        sel <= 4'hF;
        wb(1'b0, warmup_pkg::OFF_LIMIT, 0);
        chk("limit reset", 32'h0000_0066, rd);
        wb(1'b0, warmup_pkg::OFF_SYSTEM_TWO, 0);
        chk("sys reset", 32'h0000_0001, rd);
        wb(1'b1, 4'h2, 32'h0000_00FF);
        wb(1'b0, 4'h2, 0);
        chk("unmapped", 32'h0000_0000, rd);
        chk("core held", 32'h0000_0000, {31'h0, core_rst_n});
        wb(1'b1, warmup_pkg::OFF_LIMIT, 32'h0000_0002);
        wait_evt(2, 6000);
        near("reset warm-up", 2 * 512 * 100 / 25 - 16);
    endtask : t_reset

    task automatic t_soft();
        int tab [5] = '{0, 1, 3, 5, 7};
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, warmup_pkg::OFF_SYSTEM_TWO, 32'h0000_0001);
            wb(1'b1, warmup_pkg::OFF_LIMIT, 32'h0000_0001);
            wb(1'b1, warmup_pkg::OFF_CONTROL, 32'(tab[i]));
            wb(1'b1, warmup_pkg::OFF_SYSTEM_TWO, 32'h0000_0003);
            wait_evt(0, 4000);
            near("soft warm-up",
                (64 << (tab[i] / 2)) * ((tab[i] % 2) ? 120 : 100) / 25);
        end
    endtask : t_soft

    task automatic t_abort();
        wb(1'b1, warmup_pkg::OFF_SYSTEM_TWO, 32'h0000_0001);
        wb(1'b1, warmup_pkg::OFF_LIMIT, 32'h0000_0004);
        wb(1'b1, warmup_pkg::OFF_SYSTEM_TWO, 32'h0000_0003);
        repeat (100) @(posedge clk);
        wb(1'b0, warmup_pkg::OFF_STATUS, 0);
        chk("busy", 32'h0000_0001, rd);
        wb(1'b1, warmup_pkg::OFF_CONTROL, 32'h0000_000B);
        wb(1'b0, warmup_pkg::OFF_CONTROL, 0);
        chk("abort clears", 32'h0000_0003, rd);
        wb(1'b0, warmup_pkg::OFF_STATUS, 0);
        chk("idle after abort", 32'h0000_0000, rd);
        wb(1'b0, warmup_pkg::OFF_SYSTEM_TWO, 0);
        chk("enables kept", 32'h0000_0003, rd);
        wb(1'b1, warmup_pkg::OFF_SYSTEM_TWO, 32'h0000_0003);
        wait_evt(0, 3000);
        chk("no restart", 32'h0000_0BB8, 32'(n));
        wb(1'b1, warmup_pkg::OFF_CONTROL, 32'h0000_0001);
        wb(1'b1, warmup_pkg::OFF_SYSTEM_TWO, 32'h0000_0001);
        wb(1'b1, warmup_pkg::OFF_SYSTEM_TWO, 32'h0000_0003);
        wait_evt(0, 6000);
        near("restart", 4 * 64 * 120 / 25);
    endtask : t_abort

    // Stop entry and release; returns after the resume pulse
    task automatic stop_cycle(input int exp);
        stop_en <= 1'b1;
        repeat (4) @(posedge clk);
        stop_en <= 1'b0;
        repeat (20) @(posedge clk);
        chk("stopped", 32'h0000_0002, {30'h0, stop_mode, hen});
        wb(1'b0, warmup_pkg::OFF_STATUS, 0);
        chk("status stopped", 32'h0000_0009, rd);
        stop_rel <= 1'b1;
        repeat (4) @(posedge clk);
        stop_rel <= 1'b0;
        wait_evt(1, 2000);
        near("stop warm-up", exp);
        chk("running", 32'h0000_0001, {30'h0, stop_mode, hen});
    endtask : stop_cycle

    task automatic t_stop();
        wb(1'b1, warmup_pkg::OFF_SYSTEM_TWO, 32'h0000_0001);
        wb(1'b1, warmup_pkg::OFF_LIMIT, 32'h0000_0001);
        stop_cycle(64 * 100 / 25 - 4);
        // Start the low oscillator, then make it the main clock before stop
        wb(1'b1, warmup_pkg::OFF_SYSTEM_TWO, 32'h0000_0003);
        wait_evt(0, 2000);
        near("soft low", 64 * 120 / 25);
        wb(1'b1, warmup_pkg::OFF_SYSTEM_TWO, 32'h0000_0007);
        stop_cycle(64 * 120 / 25);
    endtask : t_stop

    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        sel = 4'hF;
        wdat = 32'h0000_0000;
        stop_en = 1'b0;
        stop_rel = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_soft();
        t_abort();
        t_stop();
        print_verdict();
    end

    initial begin
        #(25 * 60000);
        bad_count++;
        print_verdict();
    end
endmodule : warmup_counter_tb

// ==== dv/warmup_osc_model.sv ====
// Oscillator circuits that run only while enabled
`timescale 1ns/1ps
module warmup_osc_model #(
    parameter int HIGH_HALF_NS = 50,
    parameter int LOW_HALF_NS = 60
) (
    input wire logic high_en_i,
    input wire logic low_en_i,
    output logic high_clk_o,
    output logic low_clk_o
);
    // ========================================
    // A stopped oscillator holds its output low
    initial begin
        high_clk_o = 1'b0;
        forever begin
            #(HIGH_HALF_NS);
            high_clk_o = high_en_i ? ~high_clk_o : 1'b0;
        end
    end
    initial begin
        low_clk_o = 1'b0;
        forever begin
            #(LOW_HALF_NS);
            low_clk_o = low_en_i ? ~low_clk_o : 1'b0;
        end
    end
endmodule : warmup_osc_model

// ==== hdl/warmup_counter.sv ====
// Oscillator warm-up counter with Wishbone register slave
`timescale 1ns/1ps
module warmup_counter (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic high_freq_clock_i,
    input wire logic low_freq_clock_i,
    input wire logic stop_enter_i,
    input wire logic stop_release_i,
    output logic core_reset_n_o,
    output logic resume_o,
    output logic warmup_done_interrupt_o,
    output logic high_osc_en_o,
    output logic low_osc_en_o,
    output logic stop_mode_o
);
    logic high_rise;
    logic low_rise;
    logic stop_req_r0;
    logic stop_req_r1;
    logic rel_req_r0;
    logic rel_req_r1;
    warmup_pkg::warm_state_e state_r;
    logic sel_r;
    logic [1:0] div_r;
    logic abort_r;
    logic [7:0] limit_r;
    logic high_en_r;
    logic low_en_r;
    logic clk_sel_r;
    logic stop_src_r;
    logic soft_src_r;
    logic soft_frozen_r;
    logic started_r;
    logic [warmup_pkg::CNT_WIDTH-1:0] count_r;
    logic core_reset_n_r;
    logic resume_r;
    logic done_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic src_tick;
    logic pre_tick;
    logic pre_clear;
    logic match;
    logic bus_req;
    logic wr_ctl;
    logic wr_lim;
    logic wr_sys;
    logic high_set;
    logic low_set;
    logic soft_start;

    // ========================================
    // Write strobes from the low byte lane
    function automatic logic wr_hit(input logic [3:0] adr, input logic [3:0] off);
        wr_hit = (adr == off);
    endfunction : wr_hit

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr_ctl = bus_req && wb_we_i && wb_sel_i[0] &&
        wr_hit(wb_adr_i, warmup_pkg::OFF_CONTROL);
    assign wr_lim = bus_req && wb_we_i && wb_sel_i[0] &&
        wr_hit(wb_adr_i, warmup_pkg::OFF_LIMIT);
    assign wr_sys = bus_req && wb_we_i && wb_sel_i[0] &&
        wr_hit(wb_adr_i, warmup_pkg::OFF_SYSTEM_TWO);

    // ========================================
    // Oscillator clock edges brought into the core domain
    warmup_edge_sync u_high_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(high_freq_clock_i),
        .rise_o(high_rise)
    );

    warmup_edge_sync u_low_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(low_freq_clock_i),
        .rise_o(low_rise)
    );

    // Stop request lines synchronised
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stop_req_r0 <= 1'b0;
            stop_req_r1 <= 1'b0;
            rel_req_r0 <= 1'b0;
            rel_req_r1 <= 1'b0;
        end else begin
            stop_req_r0 <= stop_enter_i;
            stop_req_r1 <= stop_req_r0;
            rel_req_r0 <= stop_release_i;
            rel_req_r1 <= rel_req_r0;
        end
    end

    // ========================================
    // Source clock choice per warm-up kind
    always_comb begin
        case (state_r)
            warmup_pkg::ST_RESET_WARM: src_tick = high_rise;
            // clock of main system at stop entry
            warmup_pkg::ST_STOP_WARM: src_tick = stop_src_r ? low_rise : high_rise;
            warmup_pkg::ST_SOFT_WARM: src_tick = soft_src_r ? low_rise : high_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // divide by 1, 2, 4 or 8
    warmup_prescaler u_prescaler (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(pre_clear),
        .tick_i(src_tick),
        .div_i(div_r),
        .tick_o(pre_tick)
    );

    assign match = started_r && (limit_r != warmup_pkg::LIMIT_ZERO) &&
        (count_r[warmup_pkg::CNT_WIDTH-1 -: warmup_pkg::CMP_WIDTH] == limit_r);

    // start only on zero-to-one of an enable
    assign high_set = wr_sys && wb_dat_i[warmup_pkg::SYS_HIGH_EN_BIT] && !high_en_r;
    assign low_set = wr_sys && wb_dat_i[warmup_pkg::SYS_LOW_EN_BIT] && !low_en_r;
    assign soft_start = (high_set || low_set) && (state_r == warmup_pkg::ST_IDLE);

    assign pre_clear = match || soft_start || (state_r == warmup_pkg::ST_IDLE) ||
        (wr_ctl && wb_dat_i[warmup_pkg::CTL_ABORT_BIT]);

    // ========================================
    // Warm-up sequencer
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= warmup_pkg::ST_RESET_WARM;
            soft_frozen_r <= 1'b0;
            stop_src_r <= 1'b0;
        end else begin
            case (state_r)
                warmup_pkg::ST_RESET_WARM: begin
                    if (match) begin
                        state_r <= warmup_pkg::ST_IDLE;
                    end
                end
                warmup_pkg::ST_IDLE: begin
                    if (stop_req_r1) begin
                        stop_src_r <= clk_sel_r;
                        soft_frozen_r <= 1'b0;
                        state_r <= warmup_pkg::ST_STOPPED;
                    end else if (soft_start) begin
                        state_r <= warmup_pkg::ST_SOFT_WARM;
                    end
                end
                warmup_pkg::ST_SOFT_WARM: begin
                    if (match || (wr_ctl && wb_dat_i[warmup_pkg::CTL_ABORT_BIT])) begin
                        state_r <= warmup_pkg::ST_IDLE;
                    end else if (stop_req_r1) begin
                        stop_src_r <= clk_sel_r;
                        soft_frozen_r <= 1'b1;
                        state_r <= warmup_pkg::ST_STOPPED;
                    end
                end
                warmup_pkg::ST_STOPPED: begin
                    if (rel_req_r1) begin
                        state_r <= warmup_pkg::ST_STOP_WARM;
                    end
                end
                warmup_pkg::ST_STOP_WARM: begin
                    if (match) begin
                        state_r <= soft_frozen_r ? warmup_pkg::ST_SOFT_WARM :
                            warmup_pkg::ST_IDLE;
                    end
                end
                default: state_r <= warmup_pkg::ST_IDLE;
            endcase
        end
    end

    // ========================================
    // 14-stage counter
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_r <= '0;
            started_r <= 1'b0;
        end else if (match || pre_clear) begin
            count_r <= '0;
            started_r <= 1'b0;
        end else if (pre_tick) begin
            count_r <= count_r + 14'h0001;
            started_r <= 1'b1;
        end
    end

    // ========================================
    // Reset release and resume pulse
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_reset_n_r <= 1'b0;
            resume_r <= 1'b0;
        end else begin
            // hold core reset until warm-up ends
            if (state_r == warmup_pkg::ST_RESET_WARM && match) begin
                core_reset_n_r <= 1'b1;
            end
            resume_r <= (state_r == warmup_pkg::ST_STOP_WARM) && match;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == warmup_pkg::ST_SOFT_WARM) && match;
        end
    end

    // ========================================
    // Control and limit registers
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sel_r <= warmup_pkg::RST_SEL;
            div_r <= warmup_pkg::RST_DIV;
            abort_r <= 1'b0;
            limit_r <= warmup_pkg::RST_LIMIT;
        end else begin
            abort_r <= 1'b0;
            if (wr_ctl) begin
                sel_r <= wb_dat_i[warmup_pkg::CTL_SEL_BIT];
                div_r <= wb_dat_i[warmup_pkg::CTL_DIV_HI:warmup_pkg::CTL_DIV_LO];
                abort_r <= wb_dat_i[warmup_pkg::CTL_ABORT_BIT];
            end
            if (wr_lim) begin
                limit_r <= wb_dat_i[7:0];
            end
        end
    end

    // system control bits driving oscillators and clock
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            high_en_r <= warmup_pkg::RST_SYS_TWO[warmup_pkg::SYS_HIGH_EN_BIT];
            low_en_r <= warmup_pkg::RST_SYS_TWO[warmup_pkg::SYS_LOW_EN_BIT];
            clk_sel_r <= warmup_pkg::RST_SYS_TWO[warmup_pkg::SYS_CLK_SEL_BIT];
            soft_src_r <= 1'b0;
        end else begin
            if (wr_sys) begin
                high_en_r <= wb_dat_i[warmup_pkg::SYS_HIGH_EN_BIT];
                low_en_r <= wb_dat_i[warmup_pkg::SYS_LOW_EN_BIT];
                clk_sel_r <= wb_dat_i[warmup_pkg::SYS_CLK_SEL_BIT];
            end
            if (soft_start) begin
                soft_src_r <= sel_r;
            end
        end
    end

    // ========================================
    // Wishbone answer, one wait cycle
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req;
            rdata_r <= 32'h0000_0000;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    warmup_pkg::OFF_CONTROL:
                        rdata_r <= {28'h000_0000, abort_r, div_r, sel_r};
                    warmup_pkg::OFF_LIMIT:
                        rdata_r <= {24'h00_0000, limit_r};
                    warmup_pkg::OFF_SYSTEM_TWO:
                        rdata_r <= {29'h0000_0000, clk_sel_r, low_en_r, high_en_r};
                    warmup_pkg::OFF_STATUS:
                        rdata_r <= {28'h000_0000,
                            state_r == warmup_pkg::ST_STOPPED,
                            soft_frozen_r,
                            done_r,
                            state_r != warmup_pkg::ST_IDLE};
                    default: rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ========================================
    // Outputs
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;
    assign core_reset_n_o = core_reset_n_r;
    assign resume_o = resume_r;
    assign warmup_done_interrupt_o = done_r;
    assign high_osc_en_o = high_en_r && (state_r != warmup_pkg::ST_STOPPED);
    assign low_osc_en_o = low_en_r && (state_r != warmup_pkg::ST_STOPPED);
    assign stop_mode_o = (state_r == warmup_pkg::ST_STOPPED);
endmodule : warmup_counter

// ==== hdl/warmup_edge_sync.sv ====
// Two-flop synchroniser with rising edge pulse for oscillator clocks
`timescale 1ns/1ps
module warmup_edge_sync (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic async_i,
    output logic rise_o
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // ========================================
    // Synchroniser and edge history
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // One-cycle pulse per source rising edge
    assign rise_o = sync_r && !last_r;
endmodule : warmup_edge_sync

// ==== hdl/warmup_pkg.sv ====
// Constants shared by the warm-up counter block
package warmup_pkg;
    // ========================================
    // Register offsets (byte addresses)
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_LIMIT = 4'h4;
    localparam logic [3:0] OFF_SYSTEM_TWO = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'hC;
    // ========================================
    // Control register fields
    localparam int CTL_SEL_BIT = 0;
    localparam int CTL_DIV_LO = 1;
    localparam int CTL_DIV_HI = 2;
    localparam int CTL_ABORT_BIT = 3;
    // System control two fields
    localparam int SYS_HIGH_EN_BIT = 0;
    localparam int SYS_LOW_EN_BIT = 1;
    localparam int SYS_CLK_SEL_BIT = 2;
    // Status fields
    localparam int STA_RUN_BIT = 0;
    localparam int STA_DONE_BIT = 1;
    localparam int STA_HOLD_BIT = 2;
    localparam int STA_STOP_BIT = 3;
    // ========================================
    // Reset values
    localparam logic RST_SEL = 1'b0;
    localparam logic [1:0] RST_DIV = 2'b11;
    localparam logic [7:0] RST_LIMIT = 8'h66;
    localparam logic [2:0] RST_SYS_TWO = 3'b001;
    // ========================================
    // Counter geometry
    localparam int CNT_WIDTH = 14;
    localparam int CMP_WIDTH = 8;
    localparam int PRE_WIDTH = 3;
    localparam logic [7:0] LIMIT_ZERO = 8'h00;
    // ========================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_RESET_WARM,
        ST_IDLE,
        ST_SOFT_WARM,
        ST_STOPPED,
        ST_STOP_WARM
    } warm_state_e;
endpackage : warmup_pkg

// ==== hdl/warmup_prescaler.sv ====
// Three-stage prescaler giving a divided count enable
`timescale 1ns/1ps
module warmup_prescaler (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic [1:0] div_i,
    output logic tick_o
);
    logic [warmup_pkg::PRE_WIDTH-1:0] stage_r;
    logic [warmup_pkg::PRE_WIDTH-1:0] mask;

    // ========================================
    // Division mask: 1, 2, 4 or 8
    always_comb begin
        case (div_i)
            2'b00: mask = 3'b000;
            2'b01: mask = 3'b001;
            2'b10: mask = 3'b011;
            default: mask = 3'b111;
        endcase
    end

    // Prescaler stages
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage_r <= 3'b000;
        end else if (clear_i) begin
            stage_r <= 3'b000;
        end else if (tick_i) begin
            stage_r <= stage_r + 3'b001;
        end
    end

    // Pass a tick once all selected stages are set
    assign tick_o = tick_i && ((stage_r & mask) == mask);
endmodule : warmup_prescaler
